// >>> include/sie_pkg.sv
// package: constants and carrier types for the safety input evaluation block
package sie_pkg;
    // ------------------------------------------------------------
    // timebase
    // ------------------------------------------------------------
    localparam int CLK_NS = 10;                         // 100 MHz system clock
    localparam int US_NS  = 1000;                       // microsecond tick
    localparam int US_CYC = (US_NS + CLK_NS - 1) / CLK_NS;
    localparam int MS_US  = 1000;                       // microseconds per ms tick

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int AW     = 8;
    localparam int N_IN   = 4;                          // three function inputs + brake
    localparam int N_CH   = 8;                          // two channels per input
    localparam int N_FN   = 3;
    localparam int N_EVT  = 12;
    localparam int FILT_W = 17;
    localparam int TOL_W  = 20;
    localparam int PER_W  = 14;
    localparam int PUL_W  = 10;
    localparam int FN_W   = 3;
    localparam int LINK_W = 18;
    localparam int CTRL_W = 8;
    localparam int SF_W   = 7;                          // function codes 1..7

    // ------------------------------------------------------------
    // limits and reset values (times in us or ms)
    // ------------------------------------------------------------
    localparam logic [FILT_W-1:0] FILT_MAX = 17'h186a0; // 100000 us
    localparam logic [FILT_W-1:0] FILT_RST = 17'h02710; // 10000 us
    localparam logic [TOL_W-1:0]  TOL_MAX  = 20'hf4240; // 1000000 us
    localparam logic [TOL_W-1:0]  TOL_RST  = 20'h02710; // 10000 us
    localparam logic [PER_W-1:0]  PER_MIN  = 14'h0001;  // 1 ms
    localparam logic [PER_W-1:0]  PER_MAX  = 14'h2710;  // 10000 ms
    localparam logic [PER_W-1:0]  PER_RST  = 14'h2710;
    localparam logic [PUL_W-1:0]  PUL_MIN  = 10'h1f4;   // 500 us
    localparam logic [PUL_W-1:0]  PUL_MAX  = 10'h3e8;   // 1000 us
    localparam logic [PUL_W-1:0]  PUL_RST  = 10'h3e8;

    // ------------------------------------------------------------
    // function codes and register layout
    // ------------------------------------------------------------
    localparam logic [FN_W-1:0]   FN_NONE            = 3'h0;
    localparam logic [FN_W-1:0]   FN_SAFE_TORQUE_OFF = 3'h1;
    localparam logic [FN_W-1:0]   FN_SAFE_BRAKE_CTRL = 3'h2;
    localparam int                LINK_STRIDE = 6;      // first [2:0], second [5:3]
    localparam logic [LINK_W-1:0] LINK_RST    = 18'h00081;
    localparam int                CHK_LSB     = 0;      // test pulse checks, brake at 3
    localparam int                ANTI_LSB    = 4;      // antivalent mode per input
    localparam logic [CTRL_W-1:0] CTRL_RST    = 8'h00;
    localparam int                DISC_LSB    = 8;      // conn events below
    localparam logic [N_EVT-1:0]  ISTAT_RST   = 12'h000;
    localparam logic [N_EVT-1:0]  IMASK_RST   = 12'h000;

    localparam logic [AW-1:0] REG_CTRL  = 8'h00;
    localparam logic [AW-1:0] REG_LINK  = 8'h04;
    localparam logic [AW-1:0] REG_PER   = 8'h08;
    localparam logic [AW-1:0] REG_PUL   = 8'h0c;
    localparam logic [AW-1:0] REG_FILT0 = 8'h10;        // four words
    localparam logic [AW-1:0] REG_TOL0  = 8'h20;        // four words
    localparam logic [AW-1:0] REG_LVL   = 8'h30;
    localparam logic [AW-1:0] REG_ISTAT = 8'h34;
    localparam logic [AW-1:0] REG_IMASK = 8'h38;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [AW-1:0] addr;
        logic [31:0]   wdata;
        logic          wr;
        logic          rd;
    } sie_bus_req_type;

    typedef struct packed {
        logic [FILT_W-1:0] filt_us;
        logic              chk_en;
        logic [PER_W-1:0]  per_ms;
        logic [PUL_W-1:0]  pul_us;
    } sie_chan_cfg_type;
endpackage : sie_pkg

// >>> src/sie_chan_filt.sv
// module: one input channel - synchroniser, debounce, test pulse watchdog
`timescale 1ns/1ps
module sie_chan_filt
    import sie_pkg::*;
(
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             arst_n,
    // pin and timebase
    input  wire logic             pin,
    input  wire logic             us_tick,
    input  wire logic             ms_tick,
    input  wire sie_chan_cfg_type cfg,
    // results
    output logic                  level_q,
    output logic                  conn_evt_q
);
    logic [2:0]        sync_q;
    logic              stab_q;
    logic              stab_prev_q;
    logic [FILT_W-1:0] fcnt_q;
    logic [PUL_W:0]    low_q;
    logic [PER_W-1:0]  wcnt_q;
    logic              pulse_ok;

    // three stages; stage one is read by stage two only
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sync_q      <= 3'h0;
            stab_q      <= 1'b0;
            stab_prev_q <= 1'b0;
        end else begin
            sync_q      <= {sync_q[1:0], pin};
            stab_q      <= (sync_q[1] == sync_q[2]) ? sync_q[2] : stab_q;
            stab_prev_q <= stab_q;
        end
    end

    // debounce: new level must stand for the filter time; zero passes at once
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            fcnt_q  <= '0;
            level_q <= 1'b0;
        end else if (stab_q == level_q) begin
            fcnt_q <= '0;
        end else if (fcnt_q >= cfg.filt_us) begin
            level_q <= stab_q;
            fcnt_q  <= '0;
        end else if (us_tick) begin
            fcnt_q <= fcnt_q + 17'h00001;
        end
    end

    // low run length in us, saturating at 1024, above the widest pulse
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            low_q <= '0;
        end else if (stab_q) begin
            low_q <= '0;
        end else if (us_tick && !low_q[PUL_W]) begin
            low_q <= low_q + 11'h001;
        end
    end

    // a dip counts when it ends no longer than the set pulse width
    assign pulse_ok = stab_q && !stab_prev_q && (low_q != '0)
                      && (low_q <= {1'b0, cfg.pul_us});

    // watchdog: only armed while checked and the input stands high
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wcnt_q     <= '0;
            conn_evt_q <= 1'b0;
        end else begin
            conn_evt_q <= 1'b0;
            if (!cfg.chk_en || !level_q || pulse_ok) begin
                wcnt_q <= '0;
            end else if (wcnt_q >= cfg.per_ms) begin
                conn_evt_q <= 1'b1;
                wcnt_q     <= '0;
            end else if (ms_tick) begin
                wcnt_q <= wcnt_q + 14'h0001;
            end
        end
    end
endmodule : sie_chan_filt

// >>> src/sie_eval.sv
// module: top of the dual-channel safety input evaluation block
`timescale 1ns/1ps
// Behaviour
// - debounce every channel with per-input filter time
// - one shared test pulse period, 1-10000 ms
// - one shared test pulse width, 500-1000 us
// - per function input test pulse check enable
// - brake feedback test pulse check enable
// - each function input triggers first linked safety function
// - optional second function fires with the first
// - channels expected equal or opposite per input
// - tolerate channel deviation up to set time
module sie_eval
    import sie_pkg::*;
#(
    parameter int US_CYCLES = US_CYC        // cycles per us tick, may shrink in simulation
) (
    // clock and reset
    input  wire logic            clk_sys,
    input  wire logic            arst_n,
    // register port
    input  wire sie_bus_req_type bus_req,
    output logic [31:0]          rd_data_q,
    // input pins, channel 2i is A and 2i+1 is B, input 3 is brake feedback
    input  wire logic [N_CH-1:0] in_pin,
    // results
    output logic [SF_W-1:0]      sf_req_q,
    output logic [N_IN-1:0]      fault_q,
    output logic                 irq_q
);
    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [11:0]            us_cnt_q;
    logic                   us_tick_q;
    logic [9:0]             ms_cnt_q;
    logic                   ms_tick_q;
    logic [CTRL_W-1:0]      ctrl_q;
    logic [LINK_W-1:0]      link_q;
    logic [PER_W-1:0]       per_q;
    logic [PUL_W-1:0]       pul_q;
    logic [FILT_W-1:0]      filt_q [N_IN];
    logic [TOL_W-1:0]       tol_q  [N_IN];
    logic [TOL_W-1:0]       tcnt_q [N_IN];
    logic [N_EVT-1:0]       istat_q;
    logic [N_EVT-1:0]       imask_q;
    logic [N_EVT-1:0]       evt;
    logic [N_EVT-1:0]       w1c;
    logic [N_CH-1:0]        lvl;
    logic [N_CH-1:0]        conn_evt;
    logic [N_CH-1:0]        chk_ch;
    logic [N_IN-1:0]        mism;
    logic [N_IN-1:0]        over;
    logic [N_IN-1:0]        disc_evt;
    logic [N_IN-1:0]        dem_q;
    logic [FN_W-1:0]        fst [N_FN];
    logic [FN_W-1:0]        snd [N_FN];
    logic [SF_W-1:0]        sf_req_d;
    logic [31:0]            rd_d;
    logic [31:0]            per_cl;
    logic [31:0]            pul_cl;
    logic [31:0]            filt_cl;
    logic [31:0]            tol_cl;
    sie_chan_cfg_type       cfg_w [N_CH];

    // out-of-range writes are pulled to the nearest legal value
    function automatic logic [31:0] clamp(logic [31:0] v, logic [31:0] lo, logic [31:0] hi);
        if (v < lo) return lo;
        if (v > hi) return hi;
        return v;
    endfunction : clamp

    // ------------------------------------------------------------
    // timebase
    // ------------------------------------------------------------
    // us tick from the system clock; all filter and tolerance times count it
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            us_cnt_q  <= '0;
            us_tick_q <= 1'b0;
        end else begin
            us_tick_q <= (us_cnt_q == 12'(US_CYCLES - 1));
            us_cnt_q  <= (us_cnt_q == 12'(US_CYCLES - 1)) ? '0 : us_cnt_q + 12'h001;
        end
    end

    // ms tick for the test pulse period
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ms_cnt_q  <= '0;
            ms_tick_q <= 1'b0;
        end else begin
            ms_tick_q <= us_tick_q && (ms_cnt_q == 10'(MS_US - 1));
            if (us_tick_q) begin
                ms_cnt_q <= (ms_cnt_q == 10'(MS_US - 1)) ? '0 : ms_cnt_q + 10'h001;
            end
        end
    end

    // ------------------------------------------------------------
    // register port
    // ------------------------------------------------------------
    assign per_cl  = clamp(bus_req.wdata, 32'(PER_MIN), 32'(PER_MAX));
    assign pul_cl  = clamp(bus_req.wdata, 32'(PUL_MIN), 32'(PUL_MAX));
    assign filt_cl = clamp(bus_req.wdata, 32'h0, 32'(FILT_MAX));
    assign tol_cl  = clamp(bus_req.wdata, 32'h0, 32'(TOL_MAX));

    // shared configuration words
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_q  <= CTRL_RST;
            link_q  <= LINK_RST;
            per_q   <= PER_RST;
            pul_q   <= PUL_RST;
            imask_q <= IMASK_RST;
        end else if (bus_req.wr) begin
            case (bus_req.addr)
                REG_CTRL:  ctrl_q  <= bus_req.wdata[CTRL_W-1:0];
                REG_LINK:  link_q  <= bus_req.wdata[LINK_W-1:0];
                REG_PER:   per_q   <= per_cl[PER_W-1:0];
                REG_PUL:   pul_q   <= pul_cl[PUL_W-1:0];
                REG_IMASK: imask_q <= bus_req.wdata[N_EVT-1:0];
                default: ;
            endcase
        end
    end

    // per-input filter and tolerance times
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < N_IN; i++) begin
                filt_q[i] <= FILT_RST;
                tol_q[i]  <= TOL_RST;
            end
        end else begin
            for (int i = 0; i < N_IN; i++) begin
                if (bus_req.wr && bus_req.addr == (REG_FILT0 | 8'(i << 2))) begin
                    filt_q[i] <= filt_cl[FILT_W-1:0];
                end
                if (bus_req.wr && bus_req.addr == (REG_TOL0 | 8'(i << 2))) begin
                    tol_q[i] <= tol_cl[TOL_W-1:0];
                end
            end
        end
    end

    // read mux; unmapped addresses read zero
    always_comb begin
        rd_d = '0;
        case (bus_req.addr)
            REG_CTRL:  rd_d = 32'(ctrl_q);
            REG_LINK:  rd_d = 32'(link_q);
            REG_PER:   rd_d = 32'(per_q);
            REG_PUL:   rd_d = 32'(pul_q);
            REG_LVL:   rd_d = 32'({fault_q, dem_q, lvl});
            REG_ISTAT: rd_d = 32'(istat_q);
            REG_IMASK: rd_d = 32'(imask_q);
            default: begin
                for (int i = 0; i < N_IN; i++) begin
                    if (bus_req.addr == (REG_FILT0 | 8'(i << 2))) rd_d = 32'(filt_q[i]);
                    if (bus_req.addr == (REG_TOL0 | 8'(i << 2)))  rd_d = 32'(tol_q[i]);
                end
            end
        endcase
    end

    // read data valid only in the cycle after the strobe
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) rd_data_q <= '0;
        else         rd_data_q <= bus_req.rd ? rd_d : '0;
    end

    // ------------------------------------------------------------
    // channels
    // ------------------------------------------------------------
    for (genvar c = 0; c < N_CH; c++) begin : g_ch
        assign chk_ch[c] = ctrl_q[CHK_LSB + c / 2];
        assign cfg_w[c]  = '{filt_us: filt_q[c / 2], chk_en: chk_ch[c],
                             per_ms: per_q, pul_us: pul_q};
        sie_chan_filt u_filt (
            .clk_sys    (clk_sys),
            .arst_n     (arst_n),
            .pin        (in_pin[c]),
            .us_tick    (us_tick_q),
            .ms_tick    (ms_tick_q),
            .cfg        (cfg_w[c]),
            .level_q    (lvl[c]),
            .conn_evt_q (conn_evt[c])
        );
    end

    // ------------------------------------------------------------
    // discrepancy check
    // ------------------------------------------------------------
    // mismatch against the expected relation, equal unless antivalent is set
    always_comb begin
        for (int i = 0; i < N_IN; i++) begin
            mism[i] = lvl[2*i] ^ lvl[2*i+1] ^ ctrl_q[ANTI_LSB + i];
            over[i] = tcnt_q[i] >= tol_q[i];
        end
    end
    assign disc_evt = mism & over & ~fault_q;

    // fault holds until the channels return to the expected relation
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < N_IN; i++) tcnt_q[i] <= '0;
            fault_q <= '0;
        end else begin
            for (int i = 0; i < N_IN; i++) begin
                if (!mism[i]) begin
                    tcnt_q[i]  <= '0;
                    fault_q[i] <= 1'b0;
                end else if (over[i]) begin
                    fault_q[i] <= 1'b1;
                end else if (us_tick_q) begin
                    tcnt_q[i] <= tcnt_q[i] + 20'h00001;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // safety function requests
    // ------------------------------------------------------------
    // demand on low A channel, discrepancy, or a pending connection error;
    // failing safe costs a spurious stop rather than a missed one
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            dem_q <= '1;
        end else begin
            for (int i = 0; i < N_IN; i++) begin
                dem_q[i] <= !lvl[2*i] || fault_q[i] || (|istat_q[2*i +: 2]);
            end
        end
    end

    // both linked functions of a demanded input fire together
    always_comb begin
        sf_req_d = '0;
        for (int i = 0; i < N_FN; i++) begin
            fst[i] = link_q[i*LINK_STRIDE +: FN_W];
            snd[i] = link_q[i*LINK_STRIDE + FN_W +: FN_W];
            if (dem_q[i] && fst[i] != FN_NONE) sf_req_d[fst[i] - 3'h1] = 1'b1;
            if (dem_q[i] && snd[i] != FN_NONE) sf_req_d[snd[i] - 3'h1] = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) sf_req_q <= '0;
        else         sf_req_q <= sf_req_d;
    end

    // ------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------
    assign evt = {disc_evt, conn_evt};
    assign w1c = (bus_req.wr && bus_req.addr == REG_ISTAT) ? bus_req.wdata[N_EVT-1:0] : '0;

    // sticky status; a new event beats a clear in the same cycle
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            istat_q <= ISTAT_RST;
            irq_q   <= 1'b0;
        end else begin
            istat_q <= (istat_q & ~w1c) | evt;
            irq_q   <= |(istat_q & imask_q);
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    sequence rd_mask_s;
        bus_req.rd && bus_req.addr == REG_IMASK;
    endsequence

    // only the first expiry raises the event; software may clear it while the fault stands
    sequence over_s;
        mism[0] && tcnt_q[0] >= tol_q[0] && !fault_q[0];
    endsequence

    sequence dem_first_s;
        dem_q[0] && fst[0] != FN_NONE;
    endsequence

    filt_range_a: assert property (
        filt_q[0] <= FILT_MAX && filt_q[1] <= FILT_MAX
        && filt_q[2] <= FILT_MAX && filt_q[3] <= FILT_MAX)
        else $error("filter time out of range");

    period_range_a: assert property (per_q >= PER_MIN && per_q <= PER_MAX)
        else $error("test pulse period out of range");

    width_range_a: assert property (pul_q >= PUL_MIN && pul_q <= PUL_MAX)
        else $error("test pulse width out of range");

    conn_gate_a: assert property ((conn_evt & ~$past(chk_ch)) == '0)
        else $error("connection error on unchecked channel");

    brake_gate_a: assert property (conn_evt[7:6] != 2'h0 |-> $past(ctrl_q[CHK_LSB + 3]))
        else $error("brake connection error while check off");

    link_first_a: assert property (dem_first_s |=> sf_req_q[$past(fst[0]) - 3'h1])
        else $error("first linked function not requested");

    link_second_a: assert property (
        dem_q[0] && snd[0] != FN_NONE |=> sf_req_q[$past(snd[0]) - 3'h1])
        else $error("second linked function not requested");

    relation_ok_a: assert property (!mism[0] |=> !fault_q[0])
        else $error("fault while channels in expected relation");

    tol_hold_a: assert property (
        $rose(fault_q[0]) |-> $past(tcnt_q[0]) >= $past(tol_q[0]))
        else $error("fault raised before tolerance time");

    disc_flag_a: assert property (over_s |=> fault_q[0] && istat_q[DISC_LSB])
        else $error("discrepancy not flagged");

    conn_sticky_a: assert property (conn_evt[0] |=> istat_q[0] ##1 dem_q[0])
        else $error("connection error not flagged");

    mask_read_a: assert property (rd_mask_s |=> rd_data_q == 32'($past(imask_q)))
        else $error("mask read back wrong");

    irq_level_a: assert property ((istat_q & imask_q) != '0 |=> irq_q)
        else $error("interrupt not raised");

    // interrupt must drop once nothing unmasked is pending
    irq_quiet_a: assert property ((istat_q & imask_q) == '0 |=> !irq_q)
        else $error("interrupt raised with nothing pending");

    // read data may only stand in the cycle after a read strobe
    rd_idle_a: assert property (!bus_req.rd |=> rd_data_q == '0)
        else $error("read data outside read cycle");

    // a clear without a fresh event empties the status bit
    stat_clear_a: assert property (w1c[0] && !conn_evt[0] |=> !istat_q[0])
        else $error("connection status not cleared");
endmodule : sie_eval

// >>> dv/sie_switch_model.sv
// model: external safety switches with a free running test pulse source
`timescale 1ns/1ps
module sie_switch_model #(
    parameter int PERIOD_CYC = 1000,
    parameter int WIDTH_CYC  = 20
) (
    // clock
    input  wire logic       clk_sys,
    // contact levels and pulsed channels
    input  wire logic [7:0] lvl,
    input  wire logic [7:0] pulse_mask,
    // wired pins
    output logic      [7:0] pins
);
    int cnt = 0;
    // pulse clock runs free, like a controller's clock output
    always_ff @(posedge clk_sys) begin
        cnt <= (cnt == PERIOD_CYC - 1) ? 0 : cnt + 1;
    end
    // low dip only where the contact is closed
    assign pins = lvl & ~(pulse_mask & {8{cnt < WIDTH_CYC}});
endmodule : sie_switch_model

// >>> dv/sie_eval_test.sv
// testbench: self-checking run of the safety input evaluation block
`timescale 1ns/1ps
module sie_eval_test
    import sie_pkg::*;
;
    logic            clk_sys = 1'b0;
    logic            arst_n  = 1'b0;
    sie_bus_req_type req     = '0;
    logic [31:0]     rd_data_q;
    logic [7:0]      lvl     = 8'h00;
    logic [7:0]      pmask   = 8'h00;
    logic [N_CH-1:0] in_pin;
    logic [SF_W-1:0] sf_req_q;
    logic [N_IN-1:0] fault_q;
    logic            irq_q;
    int              n_errors = 0;
    int              samples_checked = 0;
    int              cycles = 0;

    always #5 clk_sys = ~clk_sys;

    // us tick shrunk to 2 cycles so ms times stay short
    sie_eval #(.US_CYCLES(2)) i_sie_eval (.clk_sys(clk_sys), .arst_n(arst_n), .bus_req(req),
        .rd_data_q(rd_data_q), .in_pin(in_pin), .sf_req_q(sf_req_q), .fault_q(fault_q),
        .irq_q(irq_q));
    sie_switch_model i_sie_switch_model (.clk_sys(clk_sys), .lvl(lvl), .pulse_mask(pmask),
        .pins(in_pin));

    task automatic complete_run;
        if (n_errors == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : complete_run

    // hang guard
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 40000) begin
            n_errors++;
            complete_run();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        req.addr <= a;
        req.wdata <= d;
        req.wr <= 1'b1;
        @(posedge clk_sys);
        req.wr <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string msg);
        @(posedge clk_sys);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge clk_sys);
        req.rd <= 1'b0;
        #1 chk(rd_data_q, exp, msg);
    endtask : rd

    task automatic t_defaults;
        logic [7:0]  ra [8] = '{REG_CTRL, REG_LINK, REG_PER, REG_PUL, REG_FILT0, REG_TOL0,
                                REG_ISTAT, 8'h40};
        logic [31:0] re [8] = '{32'(CTRL_RST), 32'(LINK_RST), 32'(PER_RST), 32'(PUL_RST),
                                32'(FILT_RST), 32'(TOL_RST), 32'(ISTAT_RST), 32'h0};
        chk(32'(sf_req_q), 32'h03, "default demand");
        for (int i = 0; i < 8; i++) rd(ra[i], re[i], "reset value");
    endtask : t_defaults

    task automatic t_clamp;
        wr(REG_PER, 32'h0);
        rd(REG_PER, 32'(PER_MIN), "period floor");
        wr(REG_PUL, 32'h0);
        rd(REG_PUL, 32'(PUL_MIN), "width floor");
        wr(8'h14, 32'h0001ffff);
        rd(8'h14, 32'(FILT_MAX), "filter ceiling");
        wr(8'h24, 32'h000fffff);
        rd(8'h24, 32'(TOL_MAX), "tolerance ceiling");
    endtask : t_clamp

    // short dip must not reach the demand, 5 us filter
    task automatic t_filter;
        wr(REG_FILT0, 32'h5);
        lvl[1:0] <= 2'b11;
        repeat (40) @(posedge clk_sys);
        #1 chk(32'(sf_req_q), 32'h02, "input released");
        rd(REG_LVL, 32'h00000e03, "level word");
        @(posedge clk_sys) lvl[0] <= 1'b0;
        repeat (3) @(posedge clk_sys);
        lvl[0] <= 1'b1;
        repeat (30) @(posedge clk_sys);
        #1 chk(32'(sf_req_q), 32'h02, "glitch ignored");
    endtask : t_filter

    task automatic t_link;
        wr(REG_LINK, 32'h99);
        lvl[0] <= 1'b0;
        repeat (40) @(posedge clk_sys);
        #1 chk(32'(sf_req_q), 32'h07, "second function");
        @(posedge clk_sys) lvl[0] <= 1'b1;
        repeat (40) @(posedge clk_sys);
        #1 chk(32'(sf_req_q), 32'h02, "both released");
    endtask : t_link

    task automatic t_disc;
        wr(REG_TOL0, 32'd50);
        lvl[1] <= 1'b0;
        repeat (60) @(posedge clk_sys);
        #1 chk(32'(fault_q), 32'h0, "inside tolerance");
        for (int i = 0; i < 300 && fault_q[0] !== 1'b1; i++) @(posedge clk_sys);
        #1 chk(32'(fault_q), 32'h1, "discrepancy fault");
        rd(REG_ISTAT, 32'h100, "discrepancy event");
        wr(REG_IMASK, 32'h100);
        rd(REG_IMASK, 32'h100, "mask readback");
        repeat (3) @(posedge clk_sys);
        #1 chk(32'(irq_q), 32'h1, "irq raised");
        wr(REG_CTRL, 32'h10);
        for (int i = 0; i < 300 && fault_q[0] !== 1'b0; i++) @(posedge clk_sys);
        #1 chk(32'(fault_q), 32'h0, "antivalent accepted");
        wr(REG_ISTAT, 32'h100);
        repeat (3) @(posedge clk_sys);
        #1 chk(32'(irq_q), 32'h0, "irq cleared");
        wr(REG_CTRL, 32'h0);
        lvl[1] <= 1'b1;
        repeat (60) @(posedge clk_sys);
    endtask : t_disc

    // pulses every 0.5 ms on input 0, brake contacts left unpulsed
    task automatic t_pulse;
        wr(8'h1c, 32'h0);
        wr(REG_PER, 32'd2);
        wr(REG_PUL, 32'd500);
        lvl[7:6] <= 2'b11;
        pmask <= 8'h03;
        wr(REG_CTRL, 32'h09);
        wr(REG_ISTAT, 32'hff);
        repeat (6000) @(posedge clk_sys);
        rd(REG_ISTAT, 32'h0c0, "brake unpulsed");
        @(posedge clk_sys) pmask <= 8'h00;
        wr(REG_ISTAT, 32'hff);
        repeat (6000) @(posedge clk_sys);
        rd(REG_ISTAT, 32'h0c3, "pulse lost");
    endtask : t_pulse

    initial begin
        repeat (5) @(posedge clk_sys);
        arst_n <= 1'b1;
        @(posedge clk_sys);
        #1 t_defaults();
        t_clamp();
        t_filter();
        t_link();
        t_disc();
        t_pulse();
        complete_run();
    end
endmodule : sie_eval_test
